// ### src/ffcl_params.svh
/*
  Constants of the fault flag and critical fault logger: register offsets,
  field positions, masks, codes and reset values.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Overview of operation
// - Low external fault line sets flag bit six
// - Alert flag set on alert, host clears
// - Only enabled fault conditions start a log
// - Log content field selects what is saved
// - Content bit two lets external fault log
// - Undervoltage enables bits 0-5 for inputs 1-6
// - Overvoltage enables split across two registers
// - Halt bit stops monitoring on external fault
// - Log written into locations 200h to 208h
// - Memory locks after one log is written
// - Stored ADC value is eight top bits
// - Writing one clears a flag bit
// - UV and OV flags masked by enables, fault outputs not
// - Log layout: flags at 201h-202h, ADC after
`ifndef FFCL_PARAMS_SVH
`define FFCL_PARAMS_SVH

`define FFCL_ADDR_W        10
`define FFCL_NCH           6
`define FFCL_ADC_W         10
`define FFCL_OFF_UV_FLAGS  10'h01B
`define FFCL_OFF_OV_FLAGS  10'h01C
`define FFCL_OFF_LOG_SEL   10'h06D
`define FFCL_OFF_UV_EN     10'h06E
`define FFCL_OFF_OV_EN_LO  10'h06F
`define FFCL_OFF_OV_EN_HI  10'h070
`define FFCL_OFF_UNUSED    10'h071
`define FFCL_OFF_EXT_ACT   10'h072
`define FFCL_OFF_LOCK      10'h08C
`define FFCL_OFF_LOG_BASE  10'h200
`define FFCL_OFF_LOG_LAST  10'h208
`define FFCL_LOG_IDX_W     4
`define FFCL_LOG_LAST_IDX  4'h8
`define FFCL_LOG_IDX_UV    4'h1
`define FFCL_LOG_IDX_OV    4'h2
`define FFCL_LOG_IDX_ADC   4'h3
`define FFCL_EXT_BIT       6
`define FFCL_ALERT_BIT     7
`define FFCL_EXT_TRIG_BIT  2
`define FFCL_HALT_BIT      5
`define FFCL_LOCK_BIT      1
`define FFCL_OV_LO_POS     4
`define FFCL_LOG_ALL       2'h0
`define FFCL_LOG_FLAGS     2'h1
`define FFCL_LOG_ADC       2'h2
`define FFCL_LOG_OFF       2'h3
`define FFCL_ZERO_BYTE     8'h00
`define FFCL_RST_LOCKED    1'h0

`endif

// ### src/ffcl_pkg.sv
/*
  Types of the fault flag and critical fault logger: state machine codes
  and the packed state records of both modules.
  Assumes ffcl_params.svh is on the include path.
*/
`include "ffcl_params.svh"

package ffcl_pkg;

  typedef enum logic [1:0] {
    FFCL_ST_IDLE = 2'h1,
    FFCL_ST_LOG  = 2'h2
  } ffcl_main_st_t;

  typedef enum logic [1:0] {
    FFCL_WR_IDLE = 2'h1,
    FFCL_WR_BUSY = 2'h2
  } ffcl_wr_st_t;

  typedef logic [7:0] ffcl_byte_t;

  typedef struct packed {
    ffcl_main_st_t          st;
    ffcl_byte_t             rdata;
    logic [`FFCL_NCH-1:0]   uv_flags;
    ffcl_byte_t             ov_flags;
    logic [2:0]             log_sel;
    logic [`FFCL_NCH-1:0]   uv_en;
    logic [3:0]             ov_en_lo;
    logic [1:0]             ov_en_hi;
    logic                   halt_en;
    logic                   locked;
    logic                   halt;
    logic                   start;
  } ffcl_main_state_t;

  typedef struct packed {
    ffcl_wr_st_t                    st;
    logic [`FFCL_LOG_IDX_W-1:0]     idx;
    logic [1:0]                     sel;
    logic [`FFCL_NCH-1:0]           uv;
    logic [`FFCL_NCH:0]             ov;
    ffcl_byte_t [`FFCL_NCH-1:0]     adc;
    ffcl_byte_t [8:0]               mem;
    logic                           done;
  } ffcl_wr_state_t;

endpackage : ffcl_pkg

// ### src/ffcl_log_store.sv
/*
  Nonvolatile fault log image: captures one snapshot on start and writes
  it byte by byte, one location per clock, then pulses done.
  Assumes start comes only while idle; read port is combinational.
*/
`timescale 1ns/1ps
`default_nettype none

`include "ffcl_params.svh"

module ffcl_log_store (
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  input  wire logic                          start,
  input  wire logic [1:0]                    content_sel,
  input  wire logic [`FFCL_NCH-1:0]          uv_trig,
  input  wire logic [`FFCL_NCH:0]            ov_trig,
  input  wire logic [`FFCL_NCH*8-1:0]        adc_snap,
  input  wire logic [`FFCL_LOG_IDX_W-1:0]    rd_idx,
  output      ffcl_pkg::ffcl_byte_t          rd_byte,
  output      logic                          done
);
  import ffcl_pkg::*;

  ffcl_wr_state_t s_ff;
  ffcl_wr_state_t nxt_s;
  logic [`FFCL_LOG_IDX_W-1:0] adc_idx;
  ffcl_byte_t                 wbyte;
  logic                       wen;

  always_comb begin
    nxt_s   = s_ff;
    nxt_s.done = 1'b0;
    adc_idx = s_ff.idx - `FFCL_LOG_IDX_ADC;
    wbyte   = `FFCL_ZERO_BYTE;
    wen     = 1'b0;
    unique case (s_ff.st)
      FFCL_WR_IDLE: begin
        if (start) begin
          nxt_s.st  = FFCL_WR_BUSY;
          nxt_s.idx = '0;
          nxt_s.sel = content_sel;
          nxt_s.uv  = uv_trig;
          nxt_s.ov  = ov_trig;
          nxt_s.adc = adc_snap;
        end
      end
      FFCL_WR_BUSY: begin
        // ******************************************
        // Byte selection per content code
        // ******************************************
        if (s_ff.idx == `FFCL_LOG_IDX_UV) begin
          wbyte = {2'h0, s_ff.uv};
          wen   = (s_ff.sel != `FFCL_LOG_ADC);
        end else if (s_ff.idx == `FFCL_LOG_IDX_OV) begin
          wbyte = {1'b0, s_ff.ov};
          wen   = (s_ff.sel != `FFCL_LOG_ADC);
        end else if (s_ff.idx >= `FFCL_LOG_IDX_ADC) begin
          wbyte = s_ff.adc[adc_idx[2:0]];
          wen   = (s_ff.sel != `FFCL_LOG_FLAGS);
        end else begin
          wen   = 1'b1;
        end
        if (wen) begin
          nxt_s.mem[s_ff.idx] = wbyte;
        end
        if (s_ff.idx == `FFCL_LOG_LAST_IDX) begin
          nxt_s.st   = FFCL_WR_IDLE;
          nxt_s.done = 1'b1;
        end else begin
          nxt_s.idx = s_ff.idx + 4'h1;
        end
      end
      default: begin
        nxt_s.st = FFCL_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_ff    <= '0;
      s_ff.st <= FFCL_WR_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rd_byte = (rd_idx > `FFCL_LOG_LAST_IDX) ? `FFCL_ZERO_BYTE : s_ff.mem[rd_idx];
  assign done    = s_ff.done;

endmodule : ffcl_log_store

`default_nettype wire

// ### src/ffcl_fault_logger.sv
/*
  Fault flag registers, critical fault enables and the one-shot fault
  logger with lock, reached through the device register port.
  Assumes a serial configuration decoder drives the register port with
  single-cycle read and write strobes; fault inputs are already deglitched.
*/
`timescale 1ns/1ps
`default_nettype none

`include "ffcl_params.svh"

module ffcl_fault_logger (
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  input  wire logic [`FFCL_ADDR_W-1:0]       reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [7:0]                    reg_wdata,
  output      ffcl_pkg::ffcl_byte_t          reg_rdata,
  input  wire logic [`FFCL_NCH-1:0]          uv_fault,
  input  wire logic [`FFCL_NCH-1:0]          ov_fault,
  input  wire logic [`FFCL_NCH*`FFCL_ADC_W-1:0] adc_result,
  input  wire logic                          multipurpose_pin_six_is_ext,
  input  wire logic                          external_fault_line_n,
  input  wire logic                          alert_driven,
  input  wire logic                          monitor_restart,
  output      logic                          monitor_halt,
  output      logic                          log_busy,
  output      logic                          log_locked
);
  import ffcl_pkg::*;

  ffcl_main_state_t s_ff;
  ffcl_main_state_t nxt_s;

  logic [`FFCL_NCH-1:0]       uv_hit;
  logic [`FFCL_NCH-1:0]       ov_hit;
  logic [`FFCL_NCH-1:0]       ov_en;
  logic                       ext_low;
  logic                       ext_trig;
  logic                       crit;
  logic [`FFCL_NCH*8-1:0]     adc_top;
  logic [`FFCL_ADDR_W-1:0]    log_off;
  ffcl_byte_t                 log_byte;
  logic                       store_done;
  ffcl_byte_t                 uv_upd;

  // ******************************************
  // Helpers
  // ******************************************
  function automatic logic wr_at(input logic [`FFCL_ADDR_W-1:0] off);
    wr_at = reg_wr && (reg_addr == off);
  endfunction : wr_at

  function automatic ffcl_byte_t flag_upd(input ffcl_byte_t cur, input ffcl_byte_t set,
                                          input ffcl_byte_t clr);
    flag_upd = (cur & ~clr) | set;
  endfunction : flag_upd

  // ******************************************
  // ADC top bits
  // ******************************************
  always_comb begin
    for (int i = 0; i < `FFCL_NCH; i++) begin
      adc_top[i*8 +: 8] = adc_result[i*`FFCL_ADC_W + `FFCL_ADC_W - 8 +: 8];
    end
  end

  // ******************************************
  // Next state
  // ******************************************
  always_comb begin
    nxt_s    = s_ff;
    nxt_s.start = 1'b0;
    ov_en    = {s_ff.ov_en_hi, s_ff.ov_en_lo};
    uv_hit   = uv_fault & s_ff.uv_en;
    ov_hit   = ov_fault & ov_en;
    ext_low  = multipurpose_pin_six_is_ext & ~external_fault_line_n;
    ext_trig = ext_low & s_ff.log_sel[`FFCL_EXT_TRIG_BIT];
    crit     = (|uv_hit) | (|ov_hit) | ext_trig;
    log_off  = reg_addr - `FFCL_OFF_LOG_BASE;

    // ******************************************
    // Fault flags
    // ******************************************
    // UV and OV bits masked by enables; set wins over a same-cycle clear
    uv_upd   = flag_upd({2'h0, s_ff.uv_flags}, {2'h0, uv_hit},
                        wr_at(`FFCL_OFF_UV_FLAGS) ? reg_wdata : `FFCL_ZERO_BYTE);
    nxt_s.uv_flags = uv_upd[`FFCL_NCH-1:0];
    nxt_s.ov_flags = flag_upd(s_ff.ov_flags, {alert_driven, ext_low, ov_hit},
                              wr_at(`FFCL_OFF_OV_FLAGS) ? reg_wdata : `FFCL_ZERO_BYTE);

    // ******************************************
    // Configuration registers
    // ******************************************
    if (wr_at(`FFCL_OFF_LOG_SEL)) begin
      nxt_s.log_sel = reg_wdata[2:0];
    end
    if (wr_at(`FFCL_OFF_UV_EN)) begin
      nxt_s.uv_en = reg_wdata[`FFCL_NCH-1:0];
    end
    if (wr_at(`FFCL_OFF_OV_EN_LO)) begin
      nxt_s.ov_en_lo = reg_wdata[7:`FFCL_OV_LO_POS];
    end
    if (wr_at(`FFCL_OFF_OV_EN_HI)) begin
      nxt_s.ov_en_hi = reg_wdata[1:0];
    end
    if (wr_at(`FFCL_OFF_EXT_ACT)) begin
      nxt_s.halt_en = reg_wdata[`FFCL_HALT_BIT];
    end

    // ******************************************
    // Log memory lock
    // ******************************************
    if (wr_at(`FFCL_OFF_LOCK)) begin
      nxt_s.locked = reg_wdata[`FFCL_LOCK_BIT];
    end
    if (store_done) begin
      nxt_s.locked = 1'b1;
    end

    // ******************************************
    // Monitoring halt
    // ******************************************
    // Halt on external fault; restart request releases it
    if (ext_low && s_ff.halt_en) begin
      nxt_s.halt = 1'b1;
    end else if (monitor_restart) begin
      nxt_s.halt = 1'b0;
    end

    // ******************************************
    // Log control
    // ******************************************
    unique case (s_ff.st)
      FFCL_ST_IDLE: begin
        if (crit && !s_ff.locked && (s_ff.log_sel[1:0] != `FFCL_LOG_OFF)) begin
          nxt_s.start = 1'b1;
          nxt_s.st    = FFCL_ST_LOG;
        end
      end
      FFCL_ST_LOG: begin
        if (store_done) begin
          nxt_s.st = FFCL_ST_IDLE;
        end
      end
      default: begin
        nxt_s.st = FFCL_ST_IDLE;
      end
    endcase

    // ******************************************
    // Register read
    // ******************************************
    if (reg_rd) begin
      if (reg_addr == `FFCL_OFF_UV_FLAGS) begin
        nxt_s.rdata = {2'h0, s_ff.uv_flags};
      end else if (reg_addr == `FFCL_OFF_OV_FLAGS) begin
        nxt_s.rdata = s_ff.ov_flags;
      end else if (reg_addr == `FFCL_OFF_LOG_SEL) begin
        nxt_s.rdata = {5'h00, s_ff.log_sel};
      end else if (reg_addr == `FFCL_OFF_UV_EN) begin
        nxt_s.rdata = {2'h0, s_ff.uv_en};
      end else if (reg_addr == `FFCL_OFF_OV_EN_LO) begin
        nxt_s.rdata = {s_ff.ov_en_lo, 4'h0};
      end else if (reg_addr == `FFCL_OFF_OV_EN_HI) begin
        nxt_s.rdata = {6'h00, s_ff.ov_en_hi};
      end else if (reg_addr == `FFCL_OFF_EXT_ACT) begin
        nxt_s.rdata = {2'h0, s_ff.halt_en, 5'h00};
      end else if (reg_addr == `FFCL_OFF_LOCK) begin
        nxt_s.rdata = {6'h00, s_ff.locked, 1'b0};
      end else if (reg_addr >= `FFCL_OFF_LOG_BASE && reg_addr <= `FFCL_OFF_LOG_LAST) begin
        nxt_s.rdata = log_byte;
      end else begin
        nxt_s.rdata = `FFCL_ZERO_BYTE;
      end
    end
  end

  // ******************************************
  // State register
  // ******************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_ff        <= '0;
      s_ff.st     <= FFCL_ST_IDLE;
      s_ff.locked <= `FFCL_RST_LOCKED;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ******************************************
  // Log image store
  // ******************************************
  ffcl_log_store u_store (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .start       (s_ff.start),
    .content_sel (s_ff.log_sel[1:0]),
    .uv_trig     (s_ff.uv_flags),
    .ov_trig     (s_ff.ov_flags[`FFCL_EXT_BIT:0]),
    .adc_snap    (adc_top),
    .rd_idx      (log_off[`FFCL_LOG_IDX_W-1:0]),
    .rd_byte     (log_byte),
    .done        (store_done)
  );

  // ******************************************
  // Outputs
  // ******************************************
  assign reg_rdata    = s_ff.rdata;
  assign monitor_halt = s_ff.halt;
  assign log_busy     = s_ff.st[1];
  assign log_locked   = s_ff.locked;

endmodule : ffcl_fault_logger

`default_nettype wire

// ### bench/ffcl_ext_src.sv
/* External fault line partner: outside circuitry pulling the line low.
   Assumes the bench asks for a pull just after a clock edge. */
`timescale 1ns/1ps
`default_nettype none

module ffcl_ext_src (
  input  wire logic clk_sys,
  input  wire logic pull,
  output logic      external_fault_line_n
);
  initial external_fault_line_n = 1'b1;
  // Pull-up: a released line reads high
  always @(posedge clk_sys) begin
    external_fault_line_n <= ~pull;
  end
endmodule : ffcl_ext_src

`default_nettype wire

// ### bench/ffcl_fault_logger_chk.sv
/* Port checker of the fault logger.
   Assumes binding onto ffcl_fault_logger, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
`include "ffcl_params.svh"

module ffcl_fault_logger_chk
  import ffcl_pkg::*;
(
  input wire logic                    clk_sys,
  input wire logic                    reset,
  input wire logic [`FFCL_ADDR_W-1:0] reg_addr,
  input wire logic                    reg_rd,
  input wire ffcl_byte_t              reg_rdata,
  input wire logic                    multipurpose_pin_six_is_ext,
  input wire logic                    external_fault_line_n,
  input wire logic                    alert_driven,
  input wire logic                    monitor_restart,
  input wire logic                    monitor_halt,
  input wire logic                    log_busy,
  input wire logic                    log_locked
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence busy_run;
    log_busy [*8] ##1 log_busy ##1 log_busy ##1 log_busy;
  endsequence
  sequence idle_locked;
    !log_busy && log_locked;
  endsequence
  log_len_a: assert property ($rose(log_busy) |-> busy_run ##1 idle_locked)
    else $error("log write length wrong");
  lock_block_a: assert property (log_locked |=> !$rose(log_busy))
    else $error("log started while locked");
  halt_cause_a: assert property ($rose(monitor_halt) |-> $past(!external_fault_line_n))
    else $error("halt without external fault");
  halt_hold_a: assert property (monitor_halt && !monitor_restart |=> monitor_halt)
    else $error("halt dropped without restart");
  ext_flag_a: assert property (reg_rd && reg_addr == `FFCL_OFF_OV_FLAGS && !$past(reset)
    && $past(multipurpose_pin_six_is_ext && !external_fault_line_n) |=> reg_rdata[6]) else $error("ext flag missing");
  alert_flag_a: assert property (reg_rd && reg_addr == `FFCL_OFF_OV_FLAGS && !$past(reset)
    && $past(alert_driven) |=> reg_rdata[7]) else $error("alert flag missing");
  uv_rsvd_a: assert property (reg_rd && reg_addr == `FFCL_OFF_UV_FLAGS |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved flag bits set");
  log_rsvd_a: assert property (reg_rd && reg_addr == `FFCL_OFF_LOG_BASE |=> reg_rdata == 8'h00)
    else $error("reserved log byte not zero");
endmodule : ffcl_fault_logger_chk

bind ffcl_fault_logger ffcl_fault_logger_chk chk_u (.clk_sys, .reset, .reg_addr, .reg_rd, .reg_rdata,
  .multipurpose_pin_six_is_ext, .external_fault_line_n, .alert_driven, .monitor_restart,
  .monitor_halt, .log_busy, .log_locked);

`default_nettype wire

// ### bench/ffcl_fault_logger_tb_top.sv
/* Self-checking bench of the fault logger with a behavioural log model.
   Assumes the design, package, checker and partner are compiled first. */
`timescale 1ns/1ps
`default_nettype none

module ffcl_fault_logger_tb_top;
  import ffcl_pkg::*;
  logic        clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        pin_ext = 1'b0, alert_driven = 1'b0, monitor_restart = 1'b0, pull = 1'b0;
  logic [9:0]  reg_addr = 10'h000;
  logic [7:0]  reg_wdata = 8'h00, mem [9];
  logic [5:0]  u, o, w;
  logic [5:0]  uv_fault = 6'h00, ov_fault = 6'h00;
  logic [59:0] adc_result = 60'h0;
  ffcl_byte_t  reg_rdata;
  wire logic   line_n;
  logic        monitor_halt, log_busy, log_locked;
  int          failures = 0, checked = 0;
  localparam logic [9:0] OFFS [6] = '{10'h06D, 10'h06E, 10'h06F, 10'h070, 10'h071, 10'h072};
  localparam logic [7:0] RBK [6] = '{8'h07, 8'h3F, 8'hF0, 8'h03, 8'h00, 8'h20};
  localparam logic [9:0] ZOFF [5] = '{10'h01B, 10'h01C, 10'h08C, 10'h200, 10'h300};

  always #50 clk_sys = ~clk_sys;

  ffcl_fault_logger dut_u (.clk_sys, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .uv_fault, .ov_fault, .adc_result, .multipurpose_pin_six_is_ext(pin_ext),
    .external_fault_line_n(line_n), .alert_driven, .monitor_restart, .monitor_halt, .log_busy, .log_locked);
  ffcl_ext_src ext_u (.clk_sys, .pull, .external_fault_line_n(line_n));

  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic step;
    @(posedge clk_sys);
    #10;
  endtask : step
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    // Idle edge keeps strobe changes of two calls apart
    step();
  endtask : wr
  task automatic rc(input logic [9:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    step();
    chk($sformatf("reg %h", a), reg_rdata, e);
  endtask : rc
  // Fault held one cycle, then the eleven-cycle write
  task automatic fault(input logic [5:0] fu, input logic [5:0] fo);
    uv_fault = fu;
    ov_fault = fo;
    step();
    uv_fault = 6'h00;
    ov_fault = 6'h00;
  endtask : fault
  task automatic log_wait;
    chk("busy", {7'h0, log_busy}, 8'h01);
    repeat (11) @(posedge clk_sys);
    #10;
    chk("done", {6'h0, log_busy, log_locked}, 8'h01);
  endtask : log_wait

  initial begin
    #(100 * 5000);
    failures++;
    test_done();
  end

  initial begin
    void'($urandom(32'hA9D7EB9E));
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (5) @(posedge clk_sys);
    #10;
    reset = 1'b0;
    foreach (ZOFF[i]) rc(ZOFF[i], 8'h00);
    foreach (OFFS[i]) begin
      rc(OFFS[i], 8'h00);
      wr(OFFS[i], 8'hFF);
      rc(OFFS[i], RBK[i]);
    end
    wr(10'h06E, 8'h15);
    wr(10'h06F, 8'h50);
    wr(10'h070, 8'h02);
    u = 6'($urandom);
    o = 6'($urandom);
    w = 6'($urandom);
    fault(u, o);
    rc(10'h01B, {2'h0, u & 6'h15});
    rc(10'h01C, {2'h0, o & 6'h25});
    chk("no log", {6'h0, log_busy, log_locked}, 8'h00);
    wr(10'h01C, {2'h0, w});
    rc(10'h01C, {2'h0, o & 6'h25 & ~w});
    wr(10'h06E, 8'h3F);
    wr(10'h06F, 8'hF0);
    wr(10'h070, 8'h03);
    for (int c = 0; c < 3; c++) begin
      wr(10'h06D, 8'(c));
      wr(10'h01B, 8'hFF);
      wr(10'h01C, 8'hFF);
      wr(10'h08C, 8'h00);
      u = 6'($urandom) | 6'h01;
      o = 6'($urandom);
      adc_result = 60'({$urandom, $urandom});
      fault(u, o);
      log_wait();
      if (c != 2) mem[1] = {2'h0, u};
      if (c != 2) mem[2] = {2'h0, o};
      for (int i = 0; i < 6; i++) if (c != 1) mem[3 + i] = adc_result[10 * i + 2 +: 8];
      for (int i = 0; i < 9; i++) rc(10'h200 + 10'(i), mem[i]);
    end
    fault(6'h3F, 6'h00);
    chk("locked", {6'h0, log_busy, log_locked}, 8'h01);
    rc(10'h201, mem[1]);
    wr(10'h01B, 8'hFF);
    wr(10'h01C, 8'hFF);
    wr(10'h06D, 8'h05);
    wr(10'h08C, 8'h00);
    pin_ext = 1'b1;
    pull = 1'b1;
    step();
    pull = 1'b0;
    step();
    chk("halt", {7'h0, monitor_halt}, 8'h01);
    log_wait();
    rc(10'h202, 8'h40);
    monitor_restart = 1'b1;
    step();
    monitor_restart = 1'b0;
    chk("restart", {7'h0, monitor_halt}, 8'h00);
    wr(10'h072, 8'h00);
    wr(10'h01C, 8'hFF);
    pull = 1'b1;
    repeat (2) step();
    rc(10'h01C, 8'h40);
    pull = 1'b0;
    chk("no halt", {7'h0, monitor_halt}, 8'h00);
    alert_driven = 1'b1;
    step();
    alert_driven = 1'b0;
    rc(10'h01C, 8'hC0);
    wr(10'h01C, 8'h80);
    rc(10'h01C, 8'h40);
    test_done();
  end
endmodule : ffcl_fault_logger_tb_top

`default_nettype wire
